// ### bench/dht_timer_chk.sv
`default_nettype none
module dht_timer_chk
  import dht_pkg::*;
#(
  parameter int OTHER_TRIGS = 3
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [2:0] block_config,
  input wire logic [1:0] first_half_mode_field,
  input wire logic ctl_wr,
  input wire logic first_half_debug_stall_bit,
  input wire logic clock_calendar_enable_bit,
  input wire logic load_wr,
  input wire logic [31:0] load_wdata,
  input wire logic timeout_mask,
  input wire logic clear_wr,
  input wire logic timeout_clear_bit,
  input wire logic debug_halt,
  input wire logic [OTHER_TRIGS-1:0] other_triggers,
  input wire logic enable_status,
  input wire logic [31:0] first_half_count_register,
  input wire logic [15:0] second_half_count_register,
  input wire logic [31:0] first_half_load_register,
  input wire logic raw_timeout_flag,
  input wire logic masked_timeout_flag,
  input wire logic converter_trigger
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  wire [31:0] cnt = first_half_count_register;
  // A load or control write in flight masks the count checks
  wire go = block_config == DHT_CFG_32_TIMER && enable_status && !load_wr && !ctl_wr;
  wire hold = debug_halt && first_half_debug_stall_bit && !clock_calendar_enable_bit;
  a_reset_state: assert property
    ($rose(nrst) |-> &cnt && &first_half_load_register) else $error("bad reset value");
  a_read_concat: assert property
    (block_config != DHT_CFG_16_SPLIT |-> second_half_count_register == cnt[31:16]) else $error("halves differ");
  a_load_both: assert property
    (load_wr && !block_config |=> first_half_load_register == $past(load_wdata)) else $error("load not taken");
  a_count_down: assert property
    (go && !hold && cnt != 32'h0 |=> cnt == $past(cnt) - 32'h1) else $error("no decrement");
  a_zero_reload: assert property
    (go && !hold && cnt == 32'h0 |=> cnt == first_half_load_register && raw_timeout_flag
      && enable_status == ($past(first_half_mode_field) != DHT_MODE_ONE_SHOT)) else $error("bad reload");
  a_halt_freeze: assert property
    (go && hold |=> cnt == $past(cnt)) else $error("count moved in halt");
  a_mask_gate: assert property
    (masked_timeout_flag == (raw_timeout_flag && timeout_mask)) else $error("masked flag wrong");
  a_flag_sticky: assert property
    (raw_timeout_flag && !(clear_wr && timeout_clear_bit) |=> raw_timeout_flag) else $error("flag dropped");
  a_trig_or: assert property
    (|other_triggers |-> converter_trigger) else $error("trigger not ored");
  a_trig_cause: assert property
    (converter_trigger && !(|other_triggers) |-> raw_timeout_flag) else $error("stray trigger");
endmodule : dht_timer_chk
bind dht_timer dht_timer_chk #(.OTHER_TRIGS(OTHER_TRIGS)) u_chk (.*);
`default_nettype wire

// ### bench/tb.sv
`default_nettype none
module tb
  import dht_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = '0, nrst = '0, ctl_wr = '0, load_wr = '0, match_wr = '0, clear_wr = '0, debug_halt = '0;
  logic first_half_enable_bit = '0, converter_trigger_enable_bit = '0, first_half_debug_stall_bit = '0;
  logic second_half_debug_stall_bit = '0, clock_calendar_enable_bit = '0, timeout_mask = '0, clock_match_mask = '0;
  logic timeout_clear_bit = '0, clock_match_clear_bit = '0, capture_compare_pwm_pin = '0;
  logic [2:0] block_config = '0, other_triggers = '0;
  logic [1:0] first_half_mode_field = '0, second_half_mode_field = '0;
  logic [31:0] load_wdata = '0, match_wdata = '0, first_half_count_register, first_half_load_register;
  logic [15:0] second_half_count_register, second_half_load_register;
  logic [7:0] first_half_prescale, second_half_prescale;
  logic enable_status, raw_timeout_flag, masked_timeout_flag, raw_clock_match_flag, masked_clock_match_flag;
  logic controller_irq, converter_trigger;
  int error_cnt = 0, check_count = 0, seed = 73;
  dht_timer dut (.*);
  always #25 ref_clk = ~ref_clk;
  // Fast toggle keeps the divider busy
  always @(posedge ref_clk) capture_compare_pwm_pin <= ~capture_compare_pwm_pin;
  task summarize;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task chk(input logic ok);
    check_count++;
    if (ok !== 1'h1) begin
      error_cnt++;
      $display("wrong value at %0t: mismatch", $time);
    end
  endtask : chk
  task pulse(input logic [3:0] k);
    @(posedge ref_clk);
    {ctl_wr, load_wr, clear_wr, match_wr} <= k;
    @(posedge ref_clk);
    {ctl_wr, load_wr, clear_wr, match_wr} <= 4'h0;
  endtask : pulse
  task run(input logic [31:0] l, input logic os);
    int m, i;
    logic h, hn, rl;
    @(posedge ref_clk);
    first_half_mode_field <= os ? DHT_MODE_ONE_SHOT : DHT_MODE_PERIODIC;
    {first_half_enable_bit, first_half_debug_stall_bit, timeout_clear_bit} <= 3'h3;
    converter_trigger_enable_bit <= !os;
    debug_halt <= 1'h0;
    load_wdata <= l + 32'h40;
    // Stop and preload far from zero, so no stray timeout
    pulse(4'hc);
    pulse(4'h2);
    first_half_enable_bit <= 1'h1;
    pulse(4'h8);
    // Load after enable so the rewrite lands mid-count
    load_wdata <= l;
    pulse(4'h4);
    for (i = 0; raw_timeout_flag !== 1'h1; i++) begin
      if (i > 99) begin
        error_cnt++;
        summarize;
      end
      @(posedge ref_clk) #1;
    end
    chk(first_half_count_register === l && converter_trigger === !os);
    m = l;
    h = 1'h0;
    for (i = 0; i < 3 * l + 9; i++) begin
      @(posedge ref_clk);
      hn = 1'($random(seed));
      debug_halt <= hn;
      timeout_mask <= 1'($random(seed));
      second_half_mode_field <= 2'($random(seed));
      #1;
      rl = !h && !os && m == 0;
      if (!h && !os) m = rl ? l : m - 1;
      h = hn;
      chk(first_half_count_register === m && converter_trigger === rl);
      chk(raw_timeout_flag === 1'h1 && enable_status === !os);
      chk(masked_timeout_flag === timeout_mask && controller_irq === timeout_mask);
    end
    $display("run done, one-shot %0d", os);
  endtask : run
  initial begin
    int i;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'h1;
    @(posedge ref_clk) #1;
    chk({first_half_count_register, first_half_load_register, second_half_load_register} === '1);
    chk({first_half_prescale, second_half_prescale, enable_status, raw_timeout_flag} === 18'h0);
    run(32'h7 + ($random(seed) & 32'hf), 1'h0);
    run(32'h3 + ($random(seed) & 32'h7), 1'h1);
    @(posedge ref_clk);
    load_wdata <= $random(seed);
    pulse(4'h4);
    #1;
    chk(first_half_load_register === load_wdata && second_half_load_register === load_wdata[31:16]);
    @(posedge ref_clk);
    block_config <= DHT_CFG_32_CLOCK;
    match_wdata <= 32'h00000001;
    @(posedge ref_clk) #1;
    chk(first_half_count_register === DHT_CLOCK_FIRST);
    pulse(4'h1);
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      other_triggers <= 3'h1 << k;
      @(posedge ref_clk) #1;
      chk(converter_trigger === 1'h1);
    end
    $display("mode and trigger test done");
    @(posedge ref_clk);
    {first_half_enable_bit, clock_calendar_enable_bit, second_half_debug_stall_bit, debug_halt} <= 4'hf;
    clock_match_mask <= 1'h1;
    pulse(4'h8);
    for (i = 0; raw_clock_match_flag !== 1'h1; i++) begin
      if (i > 70000) begin
        error_cnt++;
        summarize;
      end
      @(posedge ref_clk) #1;
    end
    // Pin rises every second cycle, so 32768 rises take 65536 cycles
    chk(i >= 65534 && i <= 65540 && first_half_count_register === 32'h0);
    chk(masked_clock_match_flag === 1'h1 && controller_irq === 1'h1);
    @(posedge ref_clk);
    clock_match_clear_bit <= 1'h1;
    pulse(4'h2);
    #1;
    chk({raw_clock_match_flag, masked_clock_match_flag, controller_irq} === 3'h0);
    $display("clock test done");
    summarize;
  end
endmodule : tb
`default_nettype wire

// ### rtl/dht_edge_div.sv
`default_nettype none
module dht_edge_div
  import dht_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic clk_in,
  output logic tick
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [14:0] cnt;
    logic tick;
  } dht_div_t;
  dht_div_t r_ff;
  dht_div_t nxt_r;
  always_comb begin
    nxt_r = r_ff;
    nxt_r.s1 = clk_in;
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
    nxt_r.tick = 1'b0;
    // [R23] edge count, wrap
    if (clr) begin
      nxt_r.cnt = '0;
    end else if (r_ff.s2 && !r_ff.s3) begin
      nxt_r.cnt = r_ff.cnt + 15'h1;
      // [R18] one tick per second
      if (r_ff.cnt == DHT_DIV_LAST) begin
        nxt_r.tick = 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end
  assign tick = r_ff.tick;
endmodule : dht_edge_div
`default_nettype wire

// ### rtl/dht_pkg.sv
// How it works
// [R1] Two 16-bit halves, split or joined
// [R2] Converter triggers of all blocks ORed
// [R3] Reset: inactive, counts/loads ffff, prescale 00
// [R4] Config 0 one-shot/periodic, 1 clock
// [R5] Config 4 selects split 16-bit operation; here the halves do not count, only loads and reads are split
// [R6] 32-bit modes act as one timer
// [R7] 32-bit load write fills both halves
// [R8] 32-bit count read concatenates both halves
// [R9] First half mode field alone chooses
// [R10] Enable starts down-count, reload after zero
// [R11] One-shot stops and clears enable
// [R12] Zero sets sticky raw timeout flag
// [R13] Mask gates masked timeout flag
// [R14] Trigger pulses only when enabled
// [R15] Load rewrite taken next cycle
// [R16] Debug stall freezes count during halt
// [R17] Clock mode counts up from one
// [R18] Clock input divided to 1 Hz
// [R19] Match rolls counter over to zero
// [R20] Match sets raw, masked flag, interrupt
// [R21] Clear bit clears clock match flags
// [R22] Clock enable overrides debug stall bits
// [R23] Synchronised edges, modulo-32768 divider
`default_nettype none
package dht_pkg;
  localparam logic [2:0] DHT_CFG_32_TIMER = 3'h0;
  localparam logic [2:0] DHT_CFG_32_CLOCK = 3'h1;
  localparam logic [2:0] DHT_CFG_16_SPLIT = 3'h4;
  localparam logic [1:0] DHT_MODE_ONE_SHOT = 2'h1;
  localparam logic [1:0] DHT_MODE_PERIODIC = 2'h2;
  localparam logic [15:0] DHT_HALF_RESET = 16'hffff;
  localparam logic [7:0] DHT_PRESCALE_RESET = 8'h00;
  localparam logic [31:0] DHT_CLOCK_FIRST = 32'h00000001;
  localparam int DHT_DIV_RATIO = 32768;
  localparam logic [14:0] DHT_DIV_LAST = 15'h7fff;
  typedef enum logic [1:0] {
    DHT_ST_IDLE,
    DHT_ST_RUN,
    DHT_ST_RELOAD
  } dht_state_t;
endpackage : dht_pkg
`default_nettype wire

// ### rtl/dht_timer.sv
`default_nettype none
module dht_timer
  import dht_pkg::*;
#(
  parameter int OTHER_TRIGS = 3
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [2:0] block_config,
  input wire logic [1:0] first_half_mode_field,
  input wire logic [1:0] second_half_mode_field,
  input wire logic ctl_wr,
  input wire logic first_half_enable_bit,
  input wire logic converter_trigger_enable_bit,
  input wire logic first_half_debug_stall_bit,
  input wire logic second_half_debug_stall_bit,
  input wire logic clock_calendar_enable_bit,
  input wire logic load_wr,
  input wire logic [31:0] load_wdata,
  input wire logic match_wr,
  input wire logic [31:0] match_wdata,
  input wire logic timeout_mask,
  input wire logic clock_match_mask,
  input wire logic clear_wr,
  input wire logic timeout_clear_bit,
  input wire logic clock_match_clear_bit,
  input wire logic debug_halt,
  input wire logic capture_compare_pwm_pin,
  input wire logic [OTHER_TRIGS-1:0] other_triggers,
  output logic enable_status,
  output logic [31:0] first_half_count_register,
  output logic [15:0] second_half_count_register,
  output logic [31:0] first_half_load_register,
  output logic [15:0] second_half_load_register,
  output logic [7:0] first_half_prescale,
  output logic [7:0] second_half_prescale,
  output logic raw_timeout_flag,
  output logic masked_timeout_flag,
  output logic raw_clock_match_flag,
  output logic masked_clock_match_flag,
  output logic controller_irq,
  output logic converter_trigger
);
  typedef struct packed {
    dht_state_t st;
    logic en;
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
    logic [15:0] ld_a;
    logic [15:0] ld_b;
    logic [31:0] match;
    logic [7:0] pre_a;
    logic [7:0] pre_b;
    logic clock_seen;
    logic to_raw;
    logic cm_raw;
    logic trig;
  } dht_state_all_t;
  dht_state_all_t r_ff;
  dht_state_all_t nxt_r;
  logic tick;
  logic is_clock;
  logic is_timer;
  logic stalled;
  logic [31:0] cnt32;
  logic [31:0] ld32;
  logic hit_zero;
  logic hit_match;
  logic [OTHER_TRIGS:0] trig_vec;

  assign cnt32 = {r_ff.cnt_b, r_ff.cnt_a};
  assign ld32 = {r_ff.ld_b, r_ff.ld_a};
  // [R4] mode select from config
  assign is_clock = (block_config == DHT_CFG_32_CLOCK);
  assign is_timer = (block_config == DHT_CFG_32_TIMER);
  // [R16] stall on debug halt
  // [R22] clock enable bit blocks every stall
  assign stalled = debug_halt && !clock_calendar_enable_bit
    && (first_half_debug_stall_bit || (is_clock && second_half_debug_stall_bit));
  assign hit_zero = is_timer && r_ff.en && !stalled && (cnt32 == 32'h0) && (r_ff.st == DHT_ST_RUN);
  assign hit_match = is_clock && r_ff.en && tick && !stalled && (cnt32 == r_ff.match);

  // [R18] divide external clock
  dht_edge_div u_div (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clr(!(is_clock && r_ff.en)),
    .clk_in(capture_compare_pwm_pin),
    .tick(tick)
  );

  always_comb begin
    logic [31:0] next32;
    next32 = cnt32;
    nxt_r = r_ff;
    nxt_r.trig = 1'b0;
    if (ctl_wr) begin
      nxt_r.en = first_half_enable_bit;
      if (first_half_enable_bit && !r_ff.en) begin
        nxt_r.st = DHT_ST_RUN;
      end
    end
    // [R7] 32-bit load fills both
    if (load_wr) begin
      nxt_r.ld_a = load_wdata[15:0];
      if (block_config != DHT_CFG_16_SPLIT) begin
        nxt_r.ld_b = load_wdata[31:16];
      end
    end
    if (match_wr) begin
      nxt_r.match = match_wdata;
    end
    // [R6] joined halves as one counter
    if (is_timer && load_wr) begin
      // [R15] new load next cycle
      // Also when stopped, so a start counts from the load
      next32 = load_wdata;
    end else if (is_timer && r_ff.en && !stalled) begin
      if (cnt32 == 32'h0) begin
        // [R10] reload after zero
        next32 = ld32;
      end else begin
        next32 = cnt32 - 32'h1;
      end
    end else if (is_clock) begin
      // [R17] first entry loads one
      if (!r_ff.clock_seen) begin
        nxt_r.clock_seen = 1'b1;
        next32 = DHT_CLOCK_FIRST;
      end else if (load_wr) begin
        next32 = load_wdata;
      end else if (r_ff.en && tick && !stalled) begin
        // [R19] roll over at match
        next32 = hit_match ? 32'h0 : cnt32 + 32'h1;
      end
    end
    // [R9] first half mode only
    // [R11] one-shot clears enable
    if (hit_zero && first_half_mode_field == DHT_MODE_ONE_SHOT && !ctl_wr) begin
      nxt_r.en = 1'b0;
      nxt_r.st = DHT_ST_IDLE;
    end
    nxt_r.cnt_a = next32[15:0];
    nxt_r.cnt_b = next32[31:16];
    // [R14] gated converter trigger
    nxt_r.trig = hit_zero && converter_trigger_enable_bit;
    // [R12] sticky timeout, set wins
    if (clear_wr && timeout_clear_bit) begin
      nxt_r.to_raw = 1'b0;
    end
    if (hit_zero) begin
      nxt_r.to_raw = 1'b1;
    end
    // [R21] clear clock match flags
    if (clear_wr && clock_match_clear_bit) begin
      nxt_r.cm_raw = 1'b0;
    end
    // [R20] match sets raw flag
    if (hit_match) begin
      nxt_r.cm_raw = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    // [R3] reset values
    if (!nrst) begin
      r_ff.st <= DHT_ST_IDLE;
      r_ff.en <= 1'b0;
      r_ff.cnt_a <= DHT_HALF_RESET;
      r_ff.cnt_b <= DHT_HALF_RESET;
      r_ff.ld_a <= DHT_HALF_RESET;
      r_ff.ld_b <= DHT_HALF_RESET;
      r_ff.match <= '0;
      r_ff.pre_a <= DHT_PRESCALE_RESET;
      r_ff.pre_b <= DHT_PRESCALE_RESET;
      r_ff.clock_seen <= 1'b0;
      r_ff.to_raw <= 1'b0;
      r_ff.cm_raw <= 1'b0;
      r_ff.trig <= 1'b0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // [R8] concatenated count read
  // [R5] split mode shows first half only
  assign first_half_count_register = (block_config == DHT_CFG_16_SPLIT) ? {16'h0, r_ff.cnt_a} : cnt32;
  assign second_half_count_register = r_ff.cnt_b;
  assign first_half_load_register = (block_config == DHT_CFG_16_SPLIT) ? {16'h0, r_ff.ld_a} : ld32;
  assign second_half_load_register = r_ff.ld_b;
  assign first_half_prescale = r_ff.pre_a;
  assign second_half_prescale = r_ff.pre_b;
  assign enable_status = r_ff.en;
  assign raw_timeout_flag = r_ff.to_raw;
  assign raw_clock_match_flag = r_ff.cm_raw;
  // [R13] masked timeout flag
  assign masked_timeout_flag = r_ff.to_raw && timeout_mask;
  // [R20] masked match and interrupt
  assign masked_clock_match_flag = r_ff.cm_raw && clock_match_mask;
  assign controller_irq = masked_timeout_flag || masked_clock_match_flag;
  // [R1] second half holds upper 16 bits in 32-bit modes
  assign trig_vec = {other_triggers, r_ff.trig};

  dht_trig_or #(
    .N(OTHER_TRIGS + 1)
  ) u_or (
    .trig_in(trig_vec),
    .trig_out(converter_trigger)
  );
endmodule : dht_timer
`default_nettype wire

// ### rtl/dht_trig_or.sv
`default_nettype none
module dht_trig_or #(
  parameter int N = 4
) (
  input wire logic [N-1:0] trig_in,
  output logic trig_out
);
  // [R2] shared converter trigger
  assign trig_out = |trig_in;
endmodule : dht_trig_or
`default_nettype wire
